// ---- hdl/dct_pkg.sv ----
// Shared constants and types of the dual counter/timer
package dct_pkg;

   // Mode-select field encoding, one field per timer
   typedef enum logic [1:0]
   {
      MODE_13BIT  = 2'b00,
      MODE_16BIT  = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT  = 2'b11
   } dct_mode_type;

   // Field positions in timer_mode_reg
   localparam int FIRST_MODE_LSB       = 0;
   localparam int FIRST_COUNTER_SELECT = 2;
   localparam int FIRST_GATE_BIT       = 3;
   localparam int SECOND_MODE_LSB      = 4;
   localparam int SECOND_COUNTER_SEL   = 6;
   localparam int SECOND_GATE_BIT      = 7;

   // Field positions in clock_select_reg
   localparam int PRESCALE_SELECT_LSB  = 0;
   localparam int FIRST_SYSCLK_SELECT  = 3;
   localparam int SECOND_SYSCLK_SELECT = 4;

   // Field positions in ext_irq_config_reg
   localparam int FIRST_IRQ_POLARITY   = 3;
   localparam int SECOND_IRQ_POLARITY  = 7;

   // Prescaler divide ratios for prescale_select 0..3
   localparam logic [5:0] PRESCALE_DIV0 = 6'h0c;
   localparam logic [5:0] PRESCALE_DIV1 = 6'h04;
   localparam logic [5:0] PRESCALE_DIV2 = 6'h30;
   localparam logic [5:0] PRESCALE_DIV3 = 6'h08;

   // Reset values
   localparam logic [7:0] COUNT_RESET   = 8'h00;
   localparam logic [5:0] PRESCALE_RST  = 6'h00;
   localparam logic [2:0] SYNC_RESET    = 3'h7;

   // Low five bits carry the 13-bit count's least significant part
   localparam logic [12:0] COUNT13_ONE  = 13'h0001;
   localparam logic [15:0] COUNT16_ONE  = 16'h0001;
   localparam logic [8:0]  COUNT8_ONE   = 9'h001;

   // Software write strobes for the count bytes with shared data
   typedef struct packed
   {
      logic       first_low;
      logic       first_high;
      logic       second_low;
      logic       second_high;
      logic [7:0] data;
   } dct_write_type;

   // Result of one count step
   typedef struct packed
   {
      logic       ovf;
      logic [7:0] hi;
      logic [7:0] lo;
   } dct_step_type;

endpackage

// ---- hdl/dct_timers.sv ----
// Two counter/timers with 13-bit, 16-bit and auto-reload modes; split mode on the first only (second holds in it)
`timescale 1ns/10ps

module dct_timers
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire logic [7:0]            i_timer_mode_reg,
   input  wire logic [7:0]            i_clock_select_reg,
   input  wire logic [7:0]            i_ext_irq_config_reg,
   input  wire logic                  i_first_run_bit,
   input  wire logic                  i_second_run_bit,
   input  wire logic                  i_first_irq_enable,
   input  wire logic                  i_second_irq_enable,
   input  wire logic                  i_first_flag_clear,
   input  wire logic                  i_second_flag_clear,
   input  wire logic                  i_first_event_pin,
   input  wire logic                  i_second_event_pin,
   input  wire logic                  i_first_ext_irq_input,
   input  wire logic                  i_second_ext_irq_input,
   input  wire dct_pkg::dct_write_type i_write,
   output logic [7:0]                 o_first_count_low_byte,
   output logic [7:0]                 o_first_count_high_byte,
   output logic [7:0]                 o_second_count_low_byte,
   output logic [7:0]                 o_second_count_high_byte,
   output logic                       o_first_overflow_flag,
   output logic                       o_second_overflow_flag,
   output logic                       o_first_irq_request,
   output logic                       o_second_irq_request,
   output logic                       o_second_overflow_pulse
);

   // ==========================================================
   // Count step for one timer in its selected mode
   function automatic dct_pkg::dct_step_type step_count
   (
      input dct_pkg::dct_mode_type mode,
      input logic [7:0]            lo,
      input logic [7:0]            hi
   );
      dct_pkg::dct_step_type r;
      logic [12:0]           c13;
      logic [15:0]           c16;
      logic [8:0]            c8;
      r.ovf = 1'b0;
      r.hi  = hi;
      r.lo  = lo;
      c13   = {hi, lo[4:0]} + dct_pkg::COUNT13_ONE;
      c16   = {hi, lo} + dct_pkg::COUNT16_ONE;
      c8    = {1'b0, lo} + dct_pkg::COUNT8_ONE;
      case (mode)
         dct_pkg::MODE_13BIT:
         begin
            // Upper low-byte bits are left as they are
            r.ovf = &{hi, lo[4:0]};
            r.hi  = c13[12:5];
            r.lo  = {lo[7:5], c13[4:0]};
         end
         dct_pkg::MODE_16BIT:
         begin
            r.ovf = &{hi, lo};
            r.hi  = c16[15:8];
            r.lo  = c16[7:0];
         end
         dct_pkg::MODE_RELOAD:
         begin
            r.ovf = c8[8];
            r.lo  = c8[8] ? hi : c8[7:0];
         end
         dct_pkg::MODE_SPLIT:
         begin
            r.ovf = c8[8];
            r.lo  = c8[7:0];
         end
         default:
         begin
            r.ovf = 1'b0;
         end
      endcase
      return r;
   endfunction

   // Active level of a gate input under its polarity bit
   function automatic logic gate_active(input logic level, input logic polarity);
      return polarity ? level : ~level;
   endfunction

   // ==========================================================
   // Configuration fields
   dct_pkg::dct_mode_type first_mode;
   dct_pkg::dct_mode_type second_mode;
   wire logic       first_counter_select  = i_timer_mode_reg[dct_pkg::FIRST_COUNTER_SELECT];
   wire logic       second_counter_select = i_timer_mode_reg[dct_pkg::SECOND_COUNTER_SEL];
   wire logic       first_gate_bit        = i_timer_mode_reg[dct_pkg::FIRST_GATE_BIT];
   wire logic       second_gate_bit       = i_timer_mode_reg[dct_pkg::SECOND_GATE_BIT];
   wire logic       first_sysclk_select   = i_clock_select_reg[dct_pkg::FIRST_SYSCLK_SELECT];
   wire logic       second_sysclk_select  = i_clock_select_reg[dct_pkg::SECOND_SYSCLK_SELECT];
   wire logic [1:0] prescale_select       =
      i_clock_select_reg[dct_pkg::PRESCALE_SELECT_LSB +: 2];
   wire logic       first_irq_polarity    = i_ext_irq_config_reg[dct_pkg::FIRST_IRQ_POLARITY];
   wire logic       second_irq_polarity   = i_ext_irq_config_reg[dct_pkg::SECOND_IRQ_POLARITY];

   assign first_mode  = dct_pkg::dct_mode_type'(i_timer_mode_reg[dct_pkg::FIRST_MODE_LSB +: 2]);
   assign second_mode = dct_pkg::dct_mode_type'(i_timer_mode_reg[dct_pkg::SECOND_MODE_LSB +: 2]);

   wire logic split_mode = (first_mode == dct_pkg::MODE_SPLIT);

   // ==========================================================
   // Input synchronisers; stage 0 feeds only stage 1
   logic [2:0] first_event_sync;
   logic [2:0] second_event_sync;
   logic [1:0] first_gate_sync;
   logic [1:0] second_gate_sync;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         first_event_sync <= dct_pkg::SYNC_RESET;
      else
         first_event_sync <= {first_event_sync[1:0], i_first_event_pin};
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         second_event_sync <= dct_pkg::SYNC_RESET;
      else
         second_event_sync <= {second_event_sync[1:0], i_second_event_pin};
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         first_gate_sync <= dct_pkg::SYNC_RESET[1:0];
      else
         first_gate_sync <= {first_gate_sync[0], i_first_ext_irq_input};
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         second_gate_sync <= dct_pkg::SYNC_RESET[1:0];
      else
         second_gate_sync <= {second_gate_sync[0], i_second_ext_irq_input};
   end

   // Sampled high followed by sampled low
   wire logic first_fall  = first_event_sync[2] & ~first_event_sync[1];
   wire logic second_fall = second_event_sync[2] & ~second_event_sync[1];

   // ==========================================================
   // Prescaler: one-cycle enable at the selected divide ratio
   function automatic logic [5:0] prescale_ratio(input logic [1:0] sel);
      logic [5:0] r;
      case (sel)
         2'h0:    r = dct_pkg::PRESCALE_DIV0;
         2'h1:    r = dct_pkg::PRESCALE_DIV1;
         2'h2:    r = dct_pkg::PRESCALE_DIV2;
         default: r = dct_pkg::PRESCALE_DIV3;
      endcase
      return r;
   endfunction

   logic [5:0] prescale_count;
   logic [5:0] prescale_div;

   assign prescale_div = prescale_ratio(prescale_select);

   wire logic prescale_tick = (prescale_count >= prescale_div - 6'h01);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         prescale_count <= dct_pkg::PRESCALE_RST;
      else if (prescale_tick)
         prescale_count <= dct_pkg::PRESCALE_RST;
      else
         prescale_count <= prescale_count + 6'h01;
   end

   // ==========================================================
   // Enables and count ticks
   wire logic first_timebase  = first_sysclk_select ? 1'b1 : prescale_tick;
   wire logic second_timebase = second_sysclk_select ? 1'b1 : prescale_tick;

   wire logic first_run = i_first_run_bit &
      (~first_gate_bit | gate_active(first_gate_sync[1], first_irq_polarity));
   wire logic second_run_normal = i_second_run_bit &
      (~second_gate_bit | gate_active(second_gate_sync[1], second_irq_polarity));

   // Second timer in split mode runs from its mode alone, no pin clock
   wire logic second_run = split_mode ? 1'b1 : second_run_normal;
   wire logic second_mode_ok = (second_mode != dct_pkg::MODE_SPLIT);

   wire logic first_tick  = first_run &
      (first_counter_select ? first_fall : first_timebase);
   wire logic second_src  = (second_counter_select & ~split_mode) ?
      second_fall : second_timebase;
   wire logic second_tick = second_run & second_mode_ok & second_src;
   wire logic split_high_tick = split_mode & i_second_run_bit & first_timebase;

   // ==========================================================
   // Next count values
   dct_pkg::dct_step_type first_step;
   dct_pkg::dct_step_type second_step;
   logic [8:0]            split_high_sum;

   assign first_step     = step_count(first_mode, o_first_count_low_byte,
                                      o_first_count_high_byte);
   assign second_step    = step_count(second_mode, o_second_count_low_byte,
                                      o_second_count_high_byte);
   assign split_high_sum = {1'b0, o_first_count_high_byte} + dct_pkg::COUNT8_ONE;

   wire logic first_ovf      = first_tick & first_step.ovf;
   wire logic second_ovf     = second_tick & second_step.ovf;
   wire logic split_high_ovf = split_high_tick & split_high_sum[8];

   // High byte of the first timer: split counter or wide-mode carry
   logic [7:0] next_first_high;
   assign next_first_high = split_mode ?
      (split_high_tick ? split_high_sum[7:0] : o_first_count_high_byte) :
      (first_tick ? first_step.hi : o_first_count_high_byte);

   logic [7:0] next_first_low;
   logic [7:0] next_second_low;
   logic [7:0] next_second_high;
   assign next_first_low   = first_tick ? first_step.lo : o_first_count_low_byte;
   assign next_second_low  = second_tick ? second_step.lo : o_second_count_low_byte;
   assign next_second_high = second_tick ? second_step.hi : o_second_count_high_byte;

   // ==========================================================
   // Count bytes; software write wins over a same-cycle step
   function automatic logic [7:0] pick_byte
   (
      input logic       load,
      input logic [7:0] data,
      input logic [7:0] step
   );
      return load ? data : step;
   endfunction

   // Without a step or a write the byte holds; run alone never clears it
   logic [7:0] load_first_low;
   logic [7:0] load_first_high;
   logic [7:0] load_second_low;
   logic [7:0] load_second_high;
   assign load_first_low   = pick_byte(i_write.first_low, i_write.data, next_first_low);
   assign load_first_high  = pick_byte(i_write.first_high, i_write.data, next_first_high);
   assign load_second_low  = pick_byte(i_write.second_low, i_write.data, next_second_low);
   assign load_second_high = pick_byte(i_write.second_high, i_write.data, next_second_high);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_first_count_low_byte <= dct_pkg::COUNT_RESET;
      else
         o_first_count_low_byte <= load_first_low;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_first_count_high_byte <= dct_pkg::COUNT_RESET;
      else
         o_first_count_high_byte <= load_first_high;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_second_count_low_byte <= dct_pkg::COUNT_RESET;
      else
         o_second_count_low_byte <= load_second_low;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_second_count_high_byte <= dct_pkg::COUNT_RESET;
      else
         o_second_count_high_byte <= load_second_high;
   end

   // ==========================================================
   // Overflow flags; a set in the clearing cycle wins
   wire logic second_flag_set = split_mode ? split_high_ovf : second_ovf;

   logic next_first_flag;
   logic next_second_flag;
   assign next_first_flag  = first_ovf |
                             (o_first_overflow_flag & ~i_first_flag_clear);
   assign next_second_flag = second_flag_set |
                             (o_second_overflow_flag & ~i_second_flag_clear);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_first_overflow_flag <= 1'b0;
      else
         o_first_overflow_flag <= next_first_flag;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_second_overflow_flag <= 1'b0;
      else
         o_second_overflow_flag <= next_second_flag;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_second_overflow_pulse <= 1'b0;
      else
         o_second_overflow_pulse <= second_ovf;
   end

   // ==========================================================
   // Interrupt requests
   assign o_first_irq_request  = o_first_overflow_flag & i_first_irq_enable;
   assign o_second_irq_request = o_second_overflow_flag & i_second_irq_enable;

endmodule

// ---- verif/dct_timers_props.sv ----
// Port assertions for the dual counter/timer
`timescale 1ns/10ps
module dct_timers_props
(
   input wire logic                   i_clk,
   input wire logic                   i_rst_n,
   input wire logic [7:0]             i_timer_mode_reg,
   input wire logic [7:0]             i_clock_select_reg,
   input wire logic                   i_first_run_bit,
   input wire logic                   i_second_run_bit,
   input wire logic                   i_first_irq_enable,
   input wire logic                   i_second_irq_enable,
   input wire logic                   i_first_flag_clear,
   input wire dct_pkg::dct_write_type i_write,
   input wire logic [7:0]             o_first_count_low_byte,
   input wire logic [7:0]             o_first_count_high_byte,
   input wire logic [7:0]             o_second_count_low_byte,
   input wire logic [7:0]             o_second_count_high_byte,
   input wire logic                   o_first_overflow_flag,
   input wire logic                   o_second_overflow_flag,
   input wire logic                   o_first_irq_request,
   input wire logic                   o_second_irq_request
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ==========================================
   // Properties
   a_irq_first_and: assert property (o_first_irq_request ==
      (o_first_overflow_flag && i_first_irq_enable)) else $error("first irq request wrong");
   a_irq_second_and: assert property (o_second_irq_request ==
      (o_second_overflow_flag && i_second_irq_enable)) else $error("second irq request wrong");
   a_write_loads: assert property (i_write.first_low |=>
      o_first_count_low_byte == $past(i_write.data)) else $error("write not loaded");
   a_stop_holds: assert property (!i_first_run_bit && i_timer_mode_reg[1:0] != 2'b11 &&
      !i_write.first_low && !i_write.first_high |=> $stable(o_first_count_low_byte)
      && $stable(o_first_count_high_byte)) else $error("count moved while stopped");
   a_flag_sticky: assert property (o_first_overflow_flag && !i_first_flag_clear |=>
      o_first_overflow_flag) else $error("flag lost without clear");
   a_wrap_sixteen: assert property (i_timer_mode_reg[3:0] == 4'h1 && i_first_run_bit &&
      i_clock_select_reg[3] && {o_first_count_high_byte, o_first_count_low_byte} == 16'hffff
      && !i_write.first_low && !i_write.first_high |=> o_first_overflow_flag &&
      {o_first_count_high_byte, o_first_count_low_byte} == 16'h0000) else $error("bad wrap");
   a_reload_copy: assert property (i_timer_mode_reg[7:4] == 4'h2 && i_second_run_bit &&
      i_timer_mode_reg[1:0] != 2'b11 && i_clock_select_reg[4] && o_second_count_low_byte
      == 8'hff && !i_write.second_low && !i_write.second_high |=> o_second_overflow_flag &&
      o_second_count_low_byte == $past(o_second_count_high_byte)) else $error("bad reload");
   a_split_noflag: assert property (i_timer_mode_reg[1:0] == 2'b11 && !i_second_run_bit &&
      !o_second_overflow_flag |=> !o_second_overflow_flag) else $error("flag set in split");
endmodule
bind dct_timers dct_timers_props dct_timers_props_i (.i_clk, .i_rst_n, .i_timer_mode_reg,
   .i_clock_select_reg, .i_first_run_bit, .i_second_run_bit, .i_first_irq_enable,
   .i_second_irq_enable, .i_first_flag_clear, .i_write, .o_first_count_low_byte,
   .o_first_count_high_byte, .o_second_count_low_byte, .o_second_count_high_byte,
   .o_first_overflow_flag, .o_second_overflow_flag, .o_first_irq_request,
   .o_second_irq_request);

// ---- verif/dct_timers_tb.sv ----
// Self-checking bench for the dual counter/timer
`timescale 1ns/10ps
module dct_timers_tb;
   logic                   i_clk = 1'b0;
   logic                   i_rst_n = 1'b0;
   logic [7:0]             timer_mode_reg = 8'h00;
   logic [7:0]             clock_select_reg = 8'h18;
   logic [7:0]             icfg = 8'h00;
   logic                   run1 = 1'b0, run2 = 1'b0, ie1 = 1'b0, ie2 = 1'b0, clr1 = 1'b0;
   logic                   clr2 = 1'b0, pin1 = 1'b1, pin2 = 1'b1, ext1 = 1'b0, ext2 = 1'b0;
   dct_pkg::dct_write_type wr = '0;
   logic [7:0]             lo1, hi1, lo2, hi2;
   logic                   f1, f2, q1, q2, pls;
   int                     num_errors = 0, tests_run = 0, pulses = 0, p0 = 0;
   int                     pre[4] = '{4, 12, 1, 6};
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) if (pls === 1'b1) pulses <= pulses + 1;
   dct_timers dct_timers_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_timer_mode_reg(timer_mode_reg),
      .i_clock_select_reg(clock_select_reg), .i_ext_irq_config_reg(icfg), .i_first_run_bit(run1),
      .i_second_run_bit(run2), .i_first_irq_enable(ie1), .i_second_irq_enable(ie2),
      .i_first_flag_clear(clr1), .i_second_flag_clear(clr2), .i_first_event_pin(pin1),
      .i_second_event_pin(pin2), .i_first_ext_irq_input(ext1), .i_second_ext_irq_input(ext2),
      .i_write(wr), .o_first_count_low_byte(lo1), .o_first_count_high_byte(hi1),
      .o_second_count_low_byte(lo2), .o_second_count_high_byte(hi2),
      .o_first_overflow_flag(f1), .o_second_overflow_flag(f2), .o_first_irq_request(q1),
      .o_second_irq_request(q2), .o_second_overflow_pulse(pls));
   // ==========================================
   // Tasks
   task tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task wb(input logic [3:0] s, input logic [7:0] d);
      @(posedge i_clk) wr <= {s, d};
      @(posedge i_clk) wr <= '0;
   endtask
   task go(input logic [1:0] w, input int n);
      @(posedge i_clk) {run2, run1} <= w;
      tick(n);
      {run2, run1} <= 2'b00;
      #1;
   endtask
   task clr;
      @(posedge i_clk) {clr2, clr1} <= 2'b11;
      @(posedge i_clk) {clr2, clr1} <= 2'b00;
      #1;
   endtask
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t count %h expected %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task results;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   initial
   begin
      tick(12);
      i_rst_n <= 1'b1;
      #1 chk16({hi1, lo1} | {hi2, lo2}, 16'h0000);
      chk1(f1 | f2, 1'b0);
      wb(4'h8, 8'h11);
      wb(4'h4, 8'h22);
      wb(4'h2, 8'h33);
      wb(4'h1, 8'h44);
      #1 chk16({hi1, lo1}, 16'h2211);
      chk16({hi2, lo2}, 16'h4433);
      @(posedge i_clk) run1 <= 1'b1;
      wr <= {4'h8, 8'h40};
      @(posedge i_clk) run1 <= 1'b0;
      wr <= '0;
      #1 chk16({hi1, lo1}, 16'h2240);
      wb(4'h8, 8'hfe);
      wb(4'h4, 8'hff);
      ie1 <= 1'b1;
      go(2'b01, 2);
      chk16({hi1, 3'b000, lo1[4:0]}, 16'h0000);
      chk1(f1 & q1 & !f2, 1'b1);
      clr;
      chk1(f1 | q1, 1'b0);
      @(posedge i_clk) timer_mode_reg <= 8'h01;
      wb(4'hc, 8'hff);
      go(2'b01, 1);
      chk16({hi1, lo1}, 16'h0000);
      chk1(f1, 1'b1);
      clr;
      for (int s = 0; s < 4; s++)
      begin
         @(posedge i_clk) clock_select_reg <= 8'h10 | 8'(s);
         wb(4'hc, 8'h00);
         go(2'b01, 48);
         chk16({hi1, lo1}, 16'(pre[s]));
      end
      @(posedge i_clk) {timer_mode_reg, icfg, clock_select_reg} <= {8'h99, 8'h08, 8'h18};
      wb(4'hf, 8'h00);
      go(2'b11, 5);
      chk16({hi1, lo1}, 16'h0000);
      chk16({hi2, lo2}, 16'h0005);
      @(posedge i_clk) ext1 <= 1'b1;
      tick(4);
      go(2'b11, 4);
      chk16({hi1, lo1}, 16'h0004);
      chk16({hi2, lo2}, 16'h0009);
      @(posedge i_clk) timer_mode_reg <= 8'h05;
      wb(4'hc, 8'h00);
      @(posedge i_clk) run1 <= 1'b1;
      repeat (5)
      begin
         @(posedge i_clk) pin1 <= 1'b0;
         @(posedge i_clk);
         @(posedge i_clk) pin1 <= 1'b1;
         @(posedge i_clk);
      end
      tick(6);
      run1 <= 1'b0;
      #1 chk16({hi1, lo1}, 16'h0005);
      @(posedge i_clk) timer_mode_reg <= 8'h20;
      wb(4'h1, 8'hfd);
      wb(4'h2, 8'hfe);
      ie2 <= 1'b1;
      p0 = pulses;
      go(2'b10, 3);
      chk16({hi2, lo2}, 16'hfdfe);
      chk1(f2 & q2, 1'b1);
      clr;
      chk16(16'(pulses - p0), 16'h0001);
      @(posedge i_clk) timer_mode_reg <= 8'h33;
      wb(4'h8, 8'hfe);
      wb(4'h4, 8'hfe);
      wb(4'h3, 8'h00);
      go(2'b01, 2);
      chk16({hi1, lo1}, 16'hfe00);
      chk1(f1 & !f2, 1'b1);
      chk16({hi2, lo2}, 16'h0000);
      clr;
      go(2'b10, 2);
      chk16({hi1, lo1}, 16'h0000);
      chk1(f2 & q2 & !f1, 1'b1);
      clr;
      wb(4'h3, 8'hff);
      p0 = pulses;
      @(posedge i_clk) timer_mode_reg <= 8'h13;
      tick(3);
      timer_mode_reg <= 8'h33;
      tick(2);
      #1 chk16({hi2, lo2}, 16'h0002);
      chk1(f2, 1'b0);
      chk16(16'(pulses - p0), 16'h0001);
      results;
   end
   initial
   begin
      tick(20000);
      num_errors++;
      results;
   end
endmodule
